// [src/amp_power_down_control.sv]
`timescale 1ns/100ps
// Behaviour
// - With internal regulators, operate and take writes 10 ms after power-stage supply is good.
// - With external core supply, wait 10 ms after it appears; ignore writes while absent.
// - Full-shutdown bit powers down everything except the register interface.
// - Bit clock and frame sync are both watched continuously for presence.
// - Missing bit clock forces all circuitry into lowest power without software.
// - Returning bit clock restarts the normal power-up sequence automatically.
// - With idle enable set, 2048 consecutive zero samples enter low-power idle.
// - Control bits 3 and 2 power down each amplifier channel independently.
// - Control bit 5 powers down the temperature converter only.
module amp_power_down_control #(
  parameter int SAMPLE_W          = 24,
  parameter int STARTUP_CYCLES    = amp_pd_pkg::STARTUP_CYCLES,
  parameter int POWERUP_CYCLES    = amp_pd_pkg::POWERUP_CYCLES,
  parameter int FRAME_SYNC_LOSS_CYCLES = amp_pd_pkg::FRAME_SYNC_LOSS_CYCLES
) (
  // System
  input  wire logic                clk_sys,
  input  wire logic                reset_n,
  // Supply monitors and straps
  input  wire logic                power_stage_supply_ok,
  input  wire logic                digital_core_supply_ok,
  input  wire logic                core_ldo_enable_pin,
  // Serial audio
  input  wire logic                bclk,
  input  wire logic                frame_sync,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] sample_data,
  // Register port
  input  wire logic                reg_wr_en,
  input  wire logic                reg_rd_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  output logic                     reg_wr_ack,
  // Power controls
  output logic                     operational,
  output amp_pd_pkg::pd_ctrl_t     pd_ctrl
);

  // One timer serves both the start-up wait and the clock-return wait
  localparam int TW = $clog2(((STARTUP_CYCLES > POWERUP_CYCLES) ? STARTUP_CYCLES : POWERUP_CYCLES) + 1);
  localparam int ZW = $clog2(amp_pd_pkg::ZERO_RUN_SAMPLES + 1);
  localparam logic [TW-1:0] START_LAST = TW'(STARTUP_CYCLES - 1);
  localparam logic [TW-1:0] PWRUP_LAST = TW'(POWERUP_CYCLES - 1);
  localparam logic [ZW-1:0] ZERO_RUN   = ZW'(amp_pd_pkg::ZERO_RUN_SAMPLES);

  amp_pd_pkg::seq_state_t state_r, state_nxt;
  logic [TW-1:0]          timer_r, timer_nxt;
  logic [ZW-1:0]          zero_cnt_r, zero_cnt_nxt;
  logic [7:0]             ctrl_r, ctrl_nxt;
  logic                   bclk_ok;
  logic                   frame_sync_ok;

  // Presence detectors on both serial clocks
  clock_presence #(.LOSS_CYCLES(amp_pd_pkg::BCLK_LOSS_CYCLES)) u_bclk_mon (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .line_in (bclk),
    .present (bclk_ok)
  );

  clock_presence #(.LOSS_CYCLES(FRAME_SYNC_LOSS_CYCLES)) u_frame_sync_mon (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .line_in (frame_sync),
    .present (frame_sync_ok)
  );

  // Supply qualification depends on whether the core rail is generated inside
  wire supply_good = core_ldo_enable_pin ? power_stage_supply_ok
                                         : (digital_core_supply_ok && power_stage_supply_ok);
  // The strap is read live, so flipping it mid-run requalifies the supplies at once
  wire core_alive  = core_ldo_enable_pin ? power_stage_supply_ok : digital_core_supply_ok;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    timer_nxt = timer_r;
    if (!supply_good) begin
      state_nxt = amp_pd_pkg::ST_STARTUP;
      timer_nxt = '0;
    end else begin
      unique case (state_r)
        amp_pd_pkg::ST_STARTUP: begin
          if (timer_r == START_LAST) begin
            state_nxt = amp_pd_pkg::ST_RUN;
            timer_nxt = '0;
          end else begin
            timer_nxt = timer_r + TW'(1);
          end
        end
        amp_pd_pkg::ST_RUN: begin
          if (!bclk_ok) begin
            state_nxt = amp_pd_pkg::ST_CLK_LOST;
          end
        end
        // Clock return uses the short power-up count rather than the full start-up delay
        amp_pd_pkg::ST_CLK_LOST: begin
          timer_nxt = '0;
          if (bclk_ok) begin
            state_nxt = amp_pd_pkg::ST_POWERUP;
          end
        end
        amp_pd_pkg::ST_POWERUP: begin
          if (!bclk_ok) begin
            state_nxt = amp_pd_pkg::ST_CLK_LOST;
            timer_nxt = '0;
          end else if (timer_r == PWRUP_LAST) begin
            state_nxt = amp_pd_pkg::ST_RUN;
            timer_nxt = '0;
          end else begin
            timer_nxt = timer_r + TW'(1);
          end
        end
      endcase
    end
  end

  // Writes are refused until the start-up delay ends or while the core rail is missing
  wire sel_ctrl   = (reg_addr == amp_pd_pkg::POWER_CONTROL_OFFSET);
  wire sel_status = (reg_addr == amp_pd_pkg::POWER_STATUS_OFFSET);
  wire regs_ready = core_alive && (state_r != amp_pd_pkg::ST_STARTUP);
  wire wr_ctrl    = reg_wr_en && regs_ready && sel_ctrl;
  wire wr_any     = reg_wr_en && regs_ready && (sel_ctrl || sel_status);
  wire rd_take    = reg_rd_en && regs_ready;

  // Reserved control bits are masked off so they read back as zero
  assign ctrl_nxt = wr_ctrl ? (reg_wdata & amp_pd_pkg::POWER_CONTROL_MASK) : ctrl_r;

  wire idle_en      = ctrl_r[amp_pd_pkg::IDLE_ENABLE_BIT];
  wire running      = (state_r == amp_pd_pkg::ST_RUN);
  wire sample_zero  = (sample_data == '0);
  wire zero_full    = (zero_cnt_r == ZERO_RUN);

  // Zero-run counter saturates; a nonzero sample or disabling idle clears it
  always_comb begin
    zero_cnt_nxt = zero_cnt_r;
    if (!idle_en || !running) begin
      zero_cnt_nxt = '0;
    end else if (sample_valid && !sample_zero) begin
      zero_cnt_nxt = '0;
    end else if (sample_valid && !zero_full) begin
      zero_cnt_nxt = zero_cnt_r + ZW'(1);
    end
  end

  wire shutdown     = ctrl_r[amp_pd_pkg::FULL_SHUTDOWN_BIT];
  // Wake-up lands one edge after the nonzero sample, since pd_ctrl is registered
  wire idle_nxt     = idle_en && zero_full && !(sample_valid && !sample_zero);
  wire oper_nxt     = (state_nxt == amp_pd_pkg::ST_RUN) && supply_good;
  // Follows the next state so power-down lands on the same edge as operational falling
  wire core_dn_nxt  = !oper_nxt || shutdown || idle_nxt;

  amp_pd_pkg::pd_ctrl_t pd_nxt;
  assign pd_nxt.core_down     = core_dn_nxt;
  assign pd_nxt.left_down     = core_dn_nxt || ctrl_r[amp_pd_pkg::LEFT_PD_BIT];
  assign pd_nxt.right_down    = core_dn_nxt || ctrl_r[amp_pd_pkg::RIGHT_PD_BIT];
  assign pd_nxt.temp_adc_down = core_dn_nxt || ctrl_r[amp_pd_pkg::TEMP_ADC_PD_BIT];
  assign pd_nxt.idle          = idle_nxt && oper_nxt;

  logic [7:0] status_w;
  assign status_w = {3'h0,
                     shutdown,
                     frame_sync_ok,
                     pd_ctrl.idle,
                     (state_r == amp_pd_pkg::ST_CLK_LOST),
                     operational};

  // Status is read-only; a write to it is acknowledged but changes nothing
  wire [7:0] rd_mux = sel_ctrl   ? ctrl_r :
                      sel_status ? status_w : 8'h00;

  // Sequencer and zero-run state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r    <= amp_pd_pkg::ST_STARTUP;
      timer_r    <= '0;
      zero_cnt_r <= '0;
    end else begin
      state_r    <= state_nxt;
      timer_r    <= timer_nxt;
      zero_cnt_r <= zero_cnt_nxt;
    end
  end

  // Register port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r     <= amp_pd_pkg::POWER_CONTROL_RESET;
      reg_rdata  <= 8'h00;
      reg_wr_ack <= 1'b0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      reg_wr_ack <= wr_any;
      if (rd_take) begin
        reg_rdata <= rd_mux;
      end
    end
  end

  // Power controls come up all-down so nothing drives before the sequencer allows it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      operational <= 1'b0;
      pd_ctrl     <= '{core_down: 1'b1, left_down: 1'b1, right_down: 1'b1, temp_adc_down: 1'b1, idle: 1'b0};
    end else begin
      operational <= oper_nxt;
      pd_ctrl     <= pd_nxt;
    end
  end

endmodule

// [src/amp_pd_pkg.sv]
package amp_pd_pkg;

  // Register map
  localparam logic [7:0] POWER_CONTROL_OFFSET = 8'h04;
  localparam logic [7:0] POWER_STATUS_OFFSET  = 8'h05;
  localparam logic [7:0] POWER_CONTROL_RESET  = 8'h00;

  // power_control field positions
  localparam int FULL_SHUTDOWN_BIT  = 0;
  localparam int IDLE_ENABLE_BIT    = 1;
  localparam int LEFT_PD_BIT        = 2;
  localparam int RIGHT_PD_BIT       = 3;
  localparam int TEMP_ADC_PD_BIT    = 5;
  localparam logic [7:0] POWER_CONTROL_MASK = 8'h2F;

  // power_status field positions
  localparam int ST_OPERATIONAL_BIT = 0;
  localparam int ST_CLOCK_LOST_BIT  = 1;
  localparam int ST_IDLE_BIT        = 2;
  localparam int ST_FRAME_SYNC_OK_BIT    = 3;
  localparam int ST_SHUTDOWN_BIT    = 4;

  // Timing
  localparam int CLK_SYS_MHZ        = 200;
  localparam int STARTUP_DELAY_MS   = 10;
  localparam int STARTUP_CYCLES     = STARTUP_DELAY_MS * 1000 * 1000 * CLK_SYS_MHZ / 1000;
  localparam int POWERUP_CYCLES     = 1024;
  localparam int BCLK_LOSS_CYCLES   = 256;
  localparam int FRAME_SYNC_LOSS_CYCLES  = 65536;
  localparam int ZERO_RUN_SAMPLES   = 2048;

  typedef enum logic [1:0] {
    ST_STARTUP,
    ST_RUN,
    ST_CLK_LOST,
    ST_POWERUP
  } seq_state_t;

  typedef struct packed {
    logic core_down;
    logic left_down;
    logic right_down;
    logic temp_adc_down;
    logic idle;
  } pd_ctrl_t;

endpackage

// [src/clock_presence.sv]
`timescale 1ns/100ps
module clock_presence #(
  parameter int LOSS_CYCLES = 256
) (
  // System
  input  wire logic clk_sys,
  input  wire logic reset_n,
  // Monitored line
  input  wire logic line_in,
  // Result
  output logic      present
);

  localparam int CW = $clog2(LOSS_CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(LOSS_CYCLES);

  logic          line_d_r;
  logic [CW-1:0] quiet_r;
  wire           edge_seen = line_in ^ line_d_r;
  wire           timed_out = (quiet_r == LIMIT);

  // Any edge proves the clock is running; silence for LOSS_CYCLES declares it gone
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      line_d_r <= 1'b0;
      quiet_r  <= '0;
      present  <= 1'b0;
    end else begin
      line_d_r <= line_in;
      if (edge_seen) begin
        quiet_r <= '0;
        present <= 1'b1;
      end else if (!timed_out) begin
        quiet_r <= quiet_r + CW'(1);
      end else begin
        present <= 1'b0;
      end
    end
  end

endmodule

// [tb/amp_pd_sva.sv]
`timescale 1ns/100ps
module amp_pd_sva #(
  parameter int SAMPLE_W = 24
) (
  // System
  input wire logic                clk_sys,
  input wire logic                reset_n,
  // Supplies
  input wire logic                power_stage_supply_ok,
  input wire logic                digital_core_supply_ok,
  input wire logic                core_ldo_enable_pin,
  // Audio
  input wire logic                bclk,
  input wire logic                sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_data,
  // Registers and power
  input wire logic                reg_wr_en,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr_ack,
  input wire logic                operational,
  input amp_pd_pkg::pd_ctrl_t     pd_ctrl
);
  logic       bclk_last_r;
  logic [8:0] still_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Cycles since the last bit clock change, saturating
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bclk_last_r <= 1'b0;
      still_r     <= 9'h000;
    end else begin
      bclk_last_r <= bclk;
      still_r     <= (bclk != bclk_last_r) ? 9'h000 : still_r + {8'h00, still_r != 9'h1FF};
    end
  end
  property p_supply_loss; !power_stage_supply_ok [*3] |-> !operational; endproperty
  a_supply_loss: assert property (p_supply_loss) else $error("running without supply");
  property p_ack_cause; reg_wr_ack |-> $past(reg_wr_en) && $past(reg_addr) inside {8'h04, 8'h05}; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without mapped write");
  property p_ack_ready; (power_stage_supply_ok && core_ldo_enable_pin) ##1 (reg_wr_en && reg_addr == 8'h04
    && operational && power_stage_supply_ok && core_ldo_enable_pin) |=> reg_wr_ack; endproperty
  a_ack_ready: assert property (p_ack_ready) else $error("write not acked");
  property p_no_core; !core_ldo_enable_pin && !digital_core_supply_ok && reg_wr_en |=> !reg_wr_ack; endproperty
  a_no_core: assert property (p_no_core) else $error("write acked without core");
  property p_core_all; pd_ctrl.core_down |-> pd_ctrl.left_down && pd_ctrl.right_down && pd_ctrl.temp_adc_down; endproperty
  a_core_all: assert property (p_core_all) else $error("block awake in shutdown");
  property p_not_run; !operational |-> pd_ctrl.core_down; endproperty
  a_not_run: assert property (p_not_run) else $error("core up outside run");
  property p_bclk_loss; still_r > 9'h109 |-> !operational && pd_ctrl.core_down; endproperty
  a_bclk_loss: assert property (p_bclk_loss) else $error("no power down on clock loss");
  property p_wake; sample_valid && sample_data != '0 |=> !pd_ctrl.idle; endproperty
  a_wake: assert property (p_wake) else $error("idle after nonzero sample");
endmodule
bind amp_power_down_control amp_pd_sva #(.SAMPLE_W(SAMPLE_W)) i_amp_pd_sva (.clk_sys, .reset_n,
  .power_stage_supply_ok, .digital_core_supply_ok, .core_ldo_enable_pin, .bclk, .sample_valid,
  .sample_data, .reg_wr_en, .reg_addr, .reg_wr_ack, .operational, .pd_ctrl);

// [tb/amp_audio_source.sv]
`timescale 1ns/100ps
module amp_audio_source (
  // Control
  input wire logic        clk_sys,
  input wire logic        clk_run,
  input wire logic        start,
  input wire logic [11:0] zeros,
  input wire logic        tail,
  // Serial audio
  output logic            bclk,
  output logic            frame_sync,
  output logic            sample_valid,
  output logic [23:0]     sample_data,
  output logic            busy
);
  logic [11:0] left_r = 12'h000;
  logic [4:0]  fs_r   = 5'h00;
  logic        bclk_r = 1'b0;
  logic        tail_r = 1'b0;
  logic        gap_r  = 1'b0;
  // Clocks stand still while stopped so the loss can be seen
  always_ff @(posedge clk_sys) begin
    bclk_r <= clk_run ? !bclk_r : bclk_r;
    fs_r   <= fs_r + {4'h0, clk_run};
    gap_r  <= !gap_r;
    if (start) begin
      left_r <= zeros;
      tail_r <= tail;
    end else if (gap_r && left_r != 12'h000) left_r <= left_r - 12'h001;
    else if (gap_r) tail_r <= 1'b0;
  end
  assign bclk         = bclk_r;
  assign frame_sync   = fs_r[4];
  assign busy         = left_r != 12'h000 || tail_r;
  assign sample_valid = gap_r && busy;
  // Outside a sample the data is junk, so only the strobe may qualify it
  assign sample_data  = !sample_valid ? {12'hA5A, left_r} : (left_r != 12'h000 ? 24'h000000 : 24'h000010);
endmodule

// [tb/test_amp_power_down_control.sv]
`timescale 1ns/100ps
module test_amp_power_down_control;
  logic clk_sys = 0, reset_n = 0, pwr_ok = 1, core_ok = 1, ldo_pin = 1, clk_run = 1, start = 0, tail = 0;
  logic reg_wr_en = 0, reg_rd_en = 0, reg_wr_ack, operational, bclk, frame_sync, sample_valid, busy;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [11:0] zeros = 0;
  logic [23:0] sample_data;
  amp_pd_pkg::pd_ctrl_t pd_ctrl;
  int fails = 0, check_count = 0;
  localparam int START_N = 50;
  amp_power_down_control #(.STARTUP_CYCLES(START_N), .POWERUP_CYCLES(16), .FRAME_SYNC_LOSS_CYCLES(512))
    i_amp_power_down_control (.clk_sys, .reset_n, .power_stage_supply_ok(pwr_ok), .digital_core_supply_ok(core_ok),
    .core_ldo_enable_pin(ldo_pin), .bclk, .frame_sync, .sample_valid, .sample_data, .reg_wr_en, .reg_rd_en,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_wr_ack, .operational, .pd_ctrl);
  amp_audio_source i_amp_audio_source (.clk_sys, .clk_run, .start, .zeros, .tail, .bclk, .frame_sync,
    .sample_valid, .sample_data, .busy);
  always #2.5 clk_sys = !clk_sys;
  task automatic check(string what, logic [23:0] seen, logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic ack);
    @(posedge clk_sys);
    reg_wr_en <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 0;
    @(negedge clk_sys);
    check("write ack", 24'(reg_wr_ack), 24'(ack));
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd_en <= 1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 0;
    @(negedge clk_sys);
    check("read data", 24'(reg_rdata), 24'(exp));
  endtask
  task automatic pd(logic [4:0] exp);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("pd_ctrl", 24'(pd_ctrl), 24'(exp));
  endtask
  task automatic send(logic [11:0] n, logic t);
    @(posedge clk_sys);
    start <= 1; zeros <= n; tail <= t;
    @(posedge clk_sys);
    start <= 0;
    cycles(1);
    repeat (5000) if (busy) @(posedge clk_sys);
    cycles(4);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_startup;
    cycles(5);
    wr(8'h04, 8'h00, 0);
    check("early op", 24'(operational), 24'h0);
    cycles(60);
    check("op", 24'(operational), 24'h1);
    rd(8'h04, 8'h00);
    $display("test startup done");
  endtask
  task automatic t_ext_core;
    @(posedge clk_sys);
    ldo_pin <= 0;
    core_ok <= 0;
    wr(8'h04, 8'h00, 0);
    @(posedge clk_sys);
    core_ok <= 1;
    cycles(30);
    wr(8'h04, 8'h00, 0);
    cycles(40);
    wr(8'h04, 8'h00, 1);
    @(posedge clk_sys);
    ldo_pin <= 1;
    cycles(2);
    check("op ext", 24'(operational), 24'h1);
    $display("test ext core done");
  endtask
  task automatic t_power_bits;
    logic [7:0] w[4] = '{8'h04, 8'h08, 8'h20, 8'hFF};
    logic [4:0] e[4] = '{5'h08, 5'h04, 5'h02, 5'h1E};
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, w[i], 1);
      pd(e[i]);
    end
    rd(8'h04, 8'h2F);
    wr(8'h33, 8'h00, 0);
    rd(8'h33, 8'h00);
    wr(8'h04, 8'h00, 1);
    pd(5'h00);
    rd(8'h05, 8'h09);
    $display("test power bits done");
  endtask
  task automatic t_clock_loss;
    wr(8'h04, 8'h01, 1);
    @(posedge clk_sys);
    clk_run <= 0;
    wr(8'h04, 8'h00, 1);
    cycles(300);
    check("op lost", 24'(operational), 24'h0);
    pd(5'h1E);
    rd(8'h05, 8'h0A);
    @(posedge clk_sys);
    clk_run <= 1;
    cycles(10);
    check("op powerup", 24'(operational), 24'h0);
    repeat (40) if (operational !== 1) @(posedge clk_sys);
    check("op back", 24'(operational), 24'h1);
    $display("test clock loss done");
  endtask
  task automatic t_idle;
    wr(8'h04, 8'h02, 1);
    send(12'h7FF, 0);
    check("idle 2047", 24'(pd_ctrl.idle), 24'h0);
    send(12'h001, 0);
    check("idle 2048", 24'(pd_ctrl.idle), 24'h1);
    rd(8'h05, 8'h0D);
    send(12'h000, 1);
    check("idle wake", 24'(pd_ctrl.idle), 24'h0);
    $display("test idle done");
  endtask
  task automatic t_supply_drop;
    @(posedge clk_sys);
    pwr_ok <= 0;
    cycles(4);
    check("op drop", 24'(operational), 24'h0);
    pd(5'h1E);
    wr(8'h04, 8'h00, 0);
    @(posedge clk_sys);
    pwr_ok <= 1;
    cycles(START_N - 1);
    @(negedge clk_sys);
    check("op before delay", 24'(operational), 24'h0);
    @(negedge clk_sys);
    check("op after delay", 24'(operational), 24'h1);
    wr(8'h04, 8'h00, 1);
    $display("test supply drop done");
  endtask
  initial begin
    cycles(2);
    reset_n <= 1;
    t_startup();
    t_ext_core();
    t_power_bits();
    t_clock_loss();
    t_idle();
    t_supply_drop();
    tally_and_finish();
  end
  initial begin
    #100000;
    fails++;
    tally_and_finish();
  end
endmodule
